// [rtl/hpc_consts.svh]
/*
 Constants for the hub port configuration and charging control block:
 register offsets, configuration byte indices, reset values and timing.
 Assumes it is included by bare name from the block; the package does not include it.
*/
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH

// clock
`define HPC_CLK_MHZ 100

// serial configuration target
`define HPC_SMB_ADDR 7'h25
`define HPC_SMB_BITS 4'h8

// register offsets
`define HPC_REG_FW_DIS 8'h00
`define HPC_REG_FW_NONREM 8'h01
`define HPC_REG_CDP_EN 8'h02
`define HPC_REG_DCP_EN 8'h03
`define HPC_REG_FC_EN 8'h04
`define HPC_REG_STATUS 8'h05
`define HPC_REG_CHG_DONE 8'h06
`define HPC_REG_PORT_STATE 8'h07

// status register bit positions
`define HPC_ST_CFG_MODE 0
`define HPC_ST_POLARITY 1

// configuration byte indices
`define HPC_CFG_VID_LO 4'h0
`define HPC_CFG_VID_HI 4'h1
`define HPC_CFG_PID_LO 4'h2
`define HPC_CFG_PID_HI 4'h3
`define HPC_CFG_PWR_OPT 4'h4
`define HPC_CFG_PORT_CNT 4'h5
`define HPC_CFG_NONREM 4'h6
`define HPC_CFG_TUNING 4'h7
`define HPC_CFG_DIS 4'h8
`define HPC_CFG_DEPTH 9

// reset values of firmware registers
`define HPC_RST_FW_DIS 8'h00
`define HPC_RST_FW_NONREM 8'h00
`define HPC_RST_CDP_EN 8'h00
`define HPC_RST_DCP_EN 8'h00
`define HPC_RST_FC_EN 8'h00

// negotiation window, milliseconds
`define HPC_T_NEG_MIN_MS 10
`define HPC_T_NEG_MAX_MS 40
`define HPC_T_NEG_MIN_CYC (`HPC_T_NEG_MIN_MS * 1000 * `HPC_CLK_MHZ)
`define HPC_T_NEG_MAX_CYC (`HPC_T_NEG_MAX_MS * 1000 * `HPC_CLK_MHZ)

`endif

// [rtl/hpc_pkg.sv]
/*
 Types for the hub port configuration and charging control block.
 Assumes the constants header is compiled alongside.
*/
package hpc_pkg;
  typedef enum logic [2:0] {
    SMB_IDLE,
    SMB_ADDR,
    SMB_CMD,
    SMB_DATA,
    SMB_ACK
  } hpc_smb_t;

  typedef enum logic [1:0] {
    CHG_OFF,
    CHG_WATCH,
    CHG_REPLY,
    CHG_DONE
  } hpc_chg_t;
endpackage

// [rtl/hpc_port_ctrl.sv]
/*
 Downstream port configuration and charging control: port disable, non-removable
 marking, power-switch polarity, reset-time serial configuration target on two
 borrowed overcurrent pins, and per-port charging handshakes.
 Assumes all inputs synchronous to REF_CLK and POR_N released after power-up.
*/
// Functional notes
// - strap 1 at reset: power enables driven active high, board pulls them down.
// - strap 0 at reset: power enables driven active low.
// - each port disabled alone by firmware, serial config or vendor request.
// - any port marked non-removable by firmware, eeprom contents or pin strap.
// - serial configuration target answers at 7-bit address 0x25.
// - configuration mode entered after power-on while chip reset is held low.
// - in configuration mode port-3 overcurrent is clock, port-4 is data.
// - configuration mode left when chip reset is released.
// - host writes ids, power options, port count, removability, tuning; applied.
// - enabled charging port watches D+ for the source level continuously.
// - on D+ source detected, drive D- source and hold it for a window.
// - negotiation complete judged by timing D+ source on to off.
// - dedicated charging port shorts D+ to D- and blocks enumeration.
// - fast-charge capability enabled separately per port.
`timescale 1ns/1ns
`include "hpc_consts.svh"

module hpc_port_ctrl #(
  parameter int NUM_PORTS = 4,
  parameter int T_NEG_MIN_CYC = `HPC_T_NEG_MIN_CYC,
  parameter int T_NEG_MAX_CYC = `HPC_T_NEG_MAX_CYC
) (
  // clock and resets
  input wire logic REF_CLK,
  input wire logic POR_N,
  input wire logic RST_N,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // straps and eeprom
  input wire logic SWITCH_POLARITY_STRAP,
  input wire logic [NUM_PORTS-1:0] NONREM_STRAP,
  input wire logic EE_NONREM_VALID,
  input wire logic [NUM_PORTS-1:0] EE_NONREM,
  // vendor request
  input wire logic VND_DIS_WE,
  input wire logic [NUM_PORTS-1:0] VND_DIS,
  // overcurrent pins, two shared with serial config
  input wire logic [NUM_PORTS-1:0] OVERCURRENT_IN,
  output logic CONFIG_SERIAL_DATA_OUT,
  output logic CONFIG_SERIAL_DATA_OE_N,
  output logic [NUM_PORTS-1:0] OVERCURRENT_FLAG,
  // port power and state
  output logic [NUM_PORTS-1:0] PORT_POWER_ENABLE_OUTPUTS,
  output logic [NUM_PORTS-1:0] PORT_ENABLED,
  output logic [NUM_PORTS-1:0] PORT_NONREM,
  // applied configuration
  output logic [15:0] CFG_VID,
  output logic [15:0] CFG_PID,
  output logic [7:0] CFG_PWR_OPT,
  output logic [7:0] CFG_TUNING,
  // charging
  input wire logic [NUM_PORTS-1:0] DP_SRC_DET,
  output logic [NUM_PORTS-1:0] DM_SRC_EN,
  output logic [NUM_PORTS-1:0] DP_DM_SHORT,
  output logic [NUM_PORTS-1:0] ENUM_BLOCK,
  output logic [NUM_PORTS-1:0] CHG_DONE_FLAG
);
  logic cfg_mode;
  logic pol;
  logic [NUM_PORTS-1:0] fw_dis, fw_nonrem, cdp_en, dcp_en, fc_en, vnd_dis;
  logic [NUM_PORTS-1:0] strap_nonrem, port_on, dis_all, port_cnt_ok;
  logic [7:0] cfg_mem [`HPC_CFG_DEPTH];
  logic scl, sda, scl_q, sda_q, scl_rise, scl_fall, smb_start, smb_stop;
  hpc_pkg::hpc_smb_t st, ack_next;
  logic [3:0] bit_cnt, idx;
  logic [7:0] shreg;
  logic byte_done, byte_ok;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

  // configuration mode tracks chip reset once power is good
  always_ff @(posedge REF_CLK) begin
    if (!POR_N) begin
      cfg_mode <= 1'b0;
    end else begin
      cfg_mode <= !RST_N;
    end
  end

  // borrowed pins while in configuration mode
  assign scl = OVERCURRENT_IN[2];
  assign sda = OVERCURRENT_IN[3];
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign smb_start = scl & scl_q & sda_q & ~sda;
  assign smb_stop = scl & scl_q & ~sda_q & sda;
  assign byte_done = scl_fall && (bit_cnt == `HPC_SMB_BITS);
  assign byte_ok = (st == hpc_pkg::SMB_ADDR) ? (shreg == {`HPC_SMB_ADDR, 1'b0}) :
                   (st == hpc_pkg::SMB_DATA) ? (idx < 4'(`HPC_CFG_DEPTH)) : 1'b1;

  always_ff @(posedge REF_CLK) begin
    if (!POR_N) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // serial configuration target, write only
  always_ff @(posedge REF_CLK) begin
    if (!POR_N || !cfg_mode) begin
      st <= hpc_pkg::SMB_IDLE;
      ack_next <= hpc_pkg::SMB_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      idx <= 4'h0;
      CONFIG_SERIAL_DATA_OE_N <= 1'b1;
    end else if (smb_start) begin
      st <= hpc_pkg::SMB_ADDR;
      bit_cnt <= 4'h0;
      CONFIG_SERIAL_DATA_OE_N <= 1'b1;
    end else if (smb_stop) begin
      st <= hpc_pkg::SMB_IDLE;
      CONFIG_SERIAL_DATA_OE_N <= 1'b1;
    end else begin
      case (st)
        hpc_pkg::SMB_ADDR, hpc_pkg::SMB_CMD, hpc_pkg::SMB_DATA: begin
          if (scl_rise && bit_cnt != `HPC_SMB_BITS) begin
            shreg <= {shreg[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            bit_cnt <= 4'h0;
            if (byte_ok) begin
              CONFIG_SERIAL_DATA_OE_N <= 1'b0;
              st <= hpc_pkg::SMB_ACK;
              ack_next <= (st == hpc_pkg::SMB_ADDR) ? hpc_pkg::SMB_CMD : hpc_pkg::SMB_DATA;
            end else begin
              st <= hpc_pkg::SMB_IDLE;
            end
            if (st == hpc_pkg::SMB_CMD) begin
              idx <= shreg[3:0];
            end
            if (st == hpc_pkg::SMB_DATA) begin
              idx <= idx + 4'h1;
            end
          end
        end
        hpc_pkg::SMB_ACK: begin
          if (scl_fall) begin
            CONFIG_SERIAL_DATA_OE_N <= 1'b1;
            st <= ack_next;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // open-drain data only ever pulls low
  always_ff @(posedge REF_CLK) begin
    CONFIG_SERIAL_DATA_OUT <= 1'b0;
  end

  // configuration bytes survive chip reset
  always_ff @(posedge REF_CLK) begin
    if (!POR_N) begin
      for (int k = 0; k < `HPC_CFG_DEPTH; k++) begin
        cfg_mem[k] <= 8'h00;
      end
    end else if (cfg_mode && st == hpc_pkg::SMB_DATA && byte_done && byte_ok) begin
      cfg_mem[idx] <= shreg;
    end
  end

  // applied configuration
  always_ff @(posedge REF_CLK) begin
    CFG_VID <= {cfg_mem[`HPC_CFG_VID_HI], cfg_mem[`HPC_CFG_VID_LO]};
    CFG_PID <= {cfg_mem[`HPC_CFG_PID_HI], cfg_mem[`HPC_CFG_PID_LO]};
    CFG_PWR_OPT <= cfg_mem[`HPC_CFG_PWR_OPT];
    CFG_TUNING <= cfg_mem[`HPC_CFG_TUNING];
  end

  // straps caught while chip reset is held
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pol <= SWITCH_POLARITY_STRAP;
      strap_nonrem <= NONREM_STRAP;
    end
  end

  // firmware registers
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      fw_dis <= NUM_PORTS'(`HPC_RST_FW_DIS);
      fw_nonrem <= NUM_PORTS'(`HPC_RST_FW_NONREM);
      cdp_en <= NUM_PORTS'(`HPC_RST_CDP_EN);
      dcp_en <= NUM_PORTS'(`HPC_RST_DCP_EN);
      fc_en <= NUM_PORTS'(`HPC_RST_FC_EN);
    end else if (REG_WR) begin
      if (reg_hit(REG_ADDR, `HPC_REG_FW_DIS)) fw_dis <= REG_WDATA[NUM_PORTS-1:0];
      if (reg_hit(REG_ADDR, `HPC_REG_FW_NONREM)) fw_nonrem <= REG_WDATA[NUM_PORTS-1:0];
      if (reg_hit(REG_ADDR, `HPC_REG_CDP_EN)) cdp_en <= REG_WDATA[NUM_PORTS-1:0];
      if (reg_hit(REG_ADDR, `HPC_REG_DCP_EN)) dcp_en <= REG_WDATA[NUM_PORTS-1:0];
      if (reg_hit(REG_ADDR, `HPC_REG_FC_EN)) fc_en <= REG_WDATA[NUM_PORTS-1:0];
    end
  end

  // vendor request disable mask
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      vnd_dis <= '0;
    end else if (VND_DIS_WE) begin
      vnd_dis <= VND_DIS;
    end
  end

  // register read, data one cycle later
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `HPC_REG_FW_DIS: REG_RDATA <= 8'(fw_dis);
        `HPC_REG_FW_NONREM: REG_RDATA <= 8'(fw_nonrem);
        `HPC_REG_CDP_EN: REG_RDATA <= 8'(cdp_en);
        `HPC_REG_DCP_EN: REG_RDATA <= 8'(dcp_en);
        `HPC_REG_FC_EN: REG_RDATA <= 8'(fc_en);
        `HPC_REG_STATUS: begin
          REG_RDATA <= 8'h00;
          REG_RDATA[`HPC_ST_CFG_MODE] <= cfg_mode;
          REG_RDATA[`HPC_ST_POLARITY] <= pol;
        end
        `HPC_REG_CHG_DONE: REG_RDATA <= 8'(CHG_DONE_FLAG);
        `HPC_REG_PORT_STATE: REG_RDATA <= 8'(PORT_ENABLED);
        default: REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // port enable, removability and power
  assign dis_all = fw_dis | vnd_dis | cfg_mem[`HPC_CFG_DIS][NUM_PORTS-1:0];
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_cnt
    assign port_cnt_ok[p] = (cfg_mem[`HPC_CFG_PORT_CNT] == 8'h00) ||
                            (8'(p) < cfg_mem[`HPC_CFG_PORT_CNT]);
  end
  assign port_on = ~dis_all & port_cnt_ok & ~OVERCURRENT_FLAG;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      PORT_ENABLED <= '0;
      PORT_NONREM <= '0;
      OVERCURRENT_FLAG <= '0;
      PORT_POWER_ENABLE_OUTPUTS <= {NUM_PORTS{~SWITCH_POLARITY_STRAP}};
    end else begin
      PORT_ENABLED <= ~dis_all & port_cnt_ok;
      PORT_NONREM <= fw_nonrem | strap_nonrem | cfg_mem[`HPC_CFG_NONREM][NUM_PORTS-1:0] |
                     (EE_NONREM_VALID ? EE_NONREM : '0);
      OVERCURRENT_FLAG <= OVERCURRENT_IN;
      PORT_POWER_ENABLE_OUTPUTS <= pol ? port_on : ~port_on;
    end
  end

  // per-port charging handshake
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chg
    hpc_pkg::hpc_chg_t cst;
    logic [31:0] cnt;
    logic cdp_on, dcp_on;
    assign cdp_on = PORT_ENABLED[p] & cdp_en[p] & fc_en[p] & ~dcp_en[p];
    assign dcp_on = dcp_en[p] & fc_en[p];

    always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
        DP_DM_SHORT[p] <= 1'b0;
        ENUM_BLOCK[p] <= 1'b0;
      end else begin
        DP_DM_SHORT[p] <= dcp_on;
        ENUM_BLOCK[p] <= dcp_on;
      end
    end

    always_ff @(posedge REF_CLK) begin
      if (!RST_N || !cdp_on) begin
        cst <= hpc_pkg::CHG_OFF;
        cnt <= 32'h0;
        DM_SRC_EN[p] <= 1'b0;
        CHG_DONE_FLAG[p] <= 1'b0;
      end else begin
        case (cst)
          hpc_pkg::CHG_OFF: begin
            cst <= hpc_pkg::CHG_WATCH;
          end
          hpc_pkg::CHG_WATCH, hpc_pkg::CHG_DONE: begin
            if (DP_SRC_DET[p]) begin
              cst <= hpc_pkg::CHG_REPLY;
              cnt <= 32'h0;
              DM_SRC_EN[p] <= 1'b1;
              CHG_DONE_FLAG[p] <= 1'b0;
            end
          end
          hpc_pkg::CHG_REPLY: begin
            cnt <= cnt + 32'h1;
            if (!DP_SRC_DET[p]) begin
              DM_SRC_EN[p] <= 1'b0;
              CHG_DONE_FLAG[p] <= (cnt >= 32'(T_NEG_MIN_CYC));
              cst <= (cnt >= 32'(T_NEG_MIN_CYC)) ? hpc_pkg::CHG_DONE : hpc_pkg::CHG_WATCH;
            end else if (cnt >= 32'(T_NEG_MAX_CYC)) begin
              DM_SRC_EN[p] <= 1'b0;
            end
          end
          default: cst <= hpc_pkg::CHG_OFF;
        endcase
      end
    end
  end

  // checks
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!POR_N);

  a_cfg_mode_entry: assert property (!RST_N |=> cfg_mode)
    else $error("config mode not entered under reset");
  a_cfg_mode_exit: assert property (RST_N |=> !cfg_mode)
    else $error("config mode not left after reset");
  a_sda_released: assert property (!cfg_mode |=> CONFIG_SERIAL_DATA_OE_N)
    else $error("serial data driven outside config mode");
  a_addr_ack: assert property (cfg_mode && RST_N == 1'b0 && st == hpc_pkg::SMB_ADDR && byte_done
      && shreg == 8'h4A && !smb_start && !smb_stop |=> !CONFIG_SERIAL_DATA_OE_N)
    else $error("own address not acknowledged");
  a_pwr_high: assert property (RST_N && pol |=> PORT_POWER_ENABLE_OUTPUTS == $past(port_on))
    else $error("power enable not active high");
  a_pwr_low: assert property (RST_N && !pol |=> PORT_POWER_ENABLE_OUTPUTS == ~$past(port_on))
    else $error("power enable not active low");
  a_port_dis: assert property (RST_N && fw_dis != '0 |=> (PORT_ENABLED & $past(fw_dis)) == '0)
    else $error("disabled port still enabled");
  a_nonrem_fw: assert property (RST_N |=> (PORT_NONREM & $past(fw_nonrem)) == $past(fw_nonrem))
    else $error("non-removable mark lost");
  a_vdm_reply: assert property (RST_N && g_chg[0].cdp_on && g_chg[0].cst == hpc_pkg::CHG_WATCH
      && DP_SRC_DET[0] ##1 g_chg[0].cdp_on |-> DM_SRC_EN[0])
    else $error("no D- reply to D+ source");
  a_dcp_short: assert property (RST_N && dcp_en[0] && fc_en[0] |=> DP_DM_SHORT[0] && ENUM_BLOCK[0])
    else $error("dedicated port not shorted");

  c_smb_ack: cover property (cfg_mode && !CONFIG_SERIAL_DATA_OE_N);
  c_chg_done: cover property (RST_N && CHG_DONE_FLAG[0]);
  c_dcp: cover property (RST_N && DP_DM_SHORT[0]);
endmodule

// [tb/hpc_pd_model.sv]
/*
 Portable charging device model on one downstream port.
 Assumes a single clock shared with the block and a one-cycle go pulse from the bench.
*/
`timescale 1ns/1ns

module hpc_pd_model (
  // clock and command
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] hold,
  // port lines
  input wire logic dm_src,
  output logic dp_src,
  output logic sdp_seen
);
  logic [7:0] cnt;
  logic seen;

  initial begin
    dp_src = 1'b0;
    sdp_seen = 1'b0;
    cnt = 8'h00;
    seen = 1'b0;
  end

  // raise d+ source, drop it hold cycles after the d- reply
  // no reply within 15 cycles: plain downstream port
  always @(posedge clk) begin
    if (go) begin
      dp_src <= 1'b1;
      sdp_seen <= 1'b0;
      seen <= 1'b0;
      cnt <= 8'h00;
    end else if (dp_src) begin
      cnt <= cnt + 8'h01;
      if (!seen && dm_src) begin
        seen <= 1'b1;
        cnt <= 8'h00;
      end else if (seen && cnt == hold) begin
        dp_src <= 1'b0;
      end else if (!seen && cnt == 8'h0F) begin
        dp_src <= 1'b0;
        sdp_seen <= 1'b1;
      end
    end
  end
endmodule

// [tb/tb.sv]
/*
 Self-checking bench for the port configuration and charging block.
 Assumes the design package, constants header and device model are compiled first.
*/
`timescale 1ns/1ns
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module tb;
  logic clk, por_n, rst_n, wr, rd, strap, ee_v, vnd_we, go, sd_out, sd_oe_n, pd_dp, pd_sdp;
  logic [7:0] addr, wdata, rdata, d, popt, tune, hold;
  logic [3:0] nr_strap, ee_nr, vnd_dis, ovc, oc_flag, pwr, pen, pnr, dm, shrt, eblk, done;
  logic [15:0] vid, pid;
  int fail_count = 0;
  int n_checks = 0;

  hpc_port_ctrl #(.NUM_PORTS(4), .T_NEG_MIN_CYC(20), .T_NEG_MAX_CYC(80)) DUT (
    .REF_CLK(clk), .POR_N(por_n), .RST_N(rst_n),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .SWITCH_POLARITY_STRAP(strap), .NONREM_STRAP(nr_strap),
    .EE_NONREM_VALID(ee_v), .EE_NONREM(ee_nr), .VND_DIS_WE(vnd_we), .VND_DIS(vnd_dis),
    .OVERCURRENT_IN(ovc), .CONFIG_SERIAL_DATA_OUT(sd_out),
    .CONFIG_SERIAL_DATA_OE_N(sd_oe_n), .OVERCURRENT_FLAG(oc_flag),
    .PORT_POWER_ENABLE_OUTPUTS(pwr), .PORT_ENABLED(pen), .PORT_NONREM(pnr),
    .CFG_VID(vid), .CFG_PID(pid), .CFG_PWR_OPT(popt), .CFG_TUNING(tune),
    .DP_SRC_DET({3'b000, pd_dp}), .DM_SRC_EN(dm), .DP_DM_SHORT(shrt),
    .ENUM_BLOCK(eblk), .CHG_DONE_FLAG(done)
  );

  hpc_pd_model PD (.clk(clk), .go(go), .hold(hold), .dm_src(dm[0]), .dp_src(pd_dp),
    .sdp_seen(pd_sdp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdata;
  endtask
  task vnd(input logic [3:0] m);
    @(posedge clk); vnd_dis <= m; vnd_we <= 1'b1;
    @(posedge clk); vnd_we <= 1'b0;
    tick(2);
  endtask
  // serial clock on overcurrent bit 2, data on bit 3
  task sl(input logic c, input logic dt);
    @(posedge clk); ovc[2] <= c; ovc[3] <= dt;
    tick(2);
  endtask
  task smb_start;
    sl(1'b1, 1'b1); sl(1'b1, 1'b0); sl(1'b0, 1'b0);
  endtask
  task smb_stop;
    sl(1'b0, 1'b0); sl(1'b1, 1'b0); sl(1'b1, 1'b1);
  endtask
  task smb_byte(input logic [7:0] b, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      sl(1'b0, b[i]); sl(1'b1, b[i]);
    end
    sl(1'b0, 1'b1); sl(1'b1, 1'b1);
    #1 `CHK(sd_oe_n, ~ack)
  endtask
  task pd_run(input logic [7:0] h, input logic exp_dm);
    @(posedge clk); hold <= h; go <= 1'b1;
    @(posedge clk); go <= 1'b0;
    tick(2);
    #1 `CHK(dm[0], exp_dm)
    for (int i = 0; i < 300 && pd_dp; i++) @(posedge clk);
    tick(3);
  endtask

  task t_config;
    smb_start; smb_byte(8'h4C, 1'b0); smb_stop;
    smb_start; smb_byte(8'h4A, 1'b1); smb_byte(8'h00, 1'b1);
    smb_byte(8'h34, 1'b1); smb_byte(8'h12, 1'b1); smb_byte(8'h78, 1'b1);
    smb_byte(8'h56, 1'b1); smb_byte(8'hA5, 1'b1); smb_stop;
    tick(2);
    `CHK(vid, 16'h1234)
    `CHK(pid, 16'h5678)
    `CHK(popt, 8'hA5)
    `CHK(pwr, 4'h0)
  endtask
  task t_release;
    @(posedge clk); rst_n <= 1'b1; ovc <= 4'h0;
    tick(3);
    reg_rd(8'h05, d); `CHK(d, 8'h02)
    `CHK(pwr, 4'hF)
    smb_start; smb_byte(8'h4A, 1'b0); smb_stop;
    @(posedge clk); ovc <= 4'h8;
    tick(3);
    `CHK(oc_flag, 4'h8)
    `CHK(pwr, 4'h7)
    @(posedge clk); ovc <= 4'h0;
    reg_rd(8'h20, d); `CHK(d, 8'h00)
  endtask
  task t_polarity;
    @(posedge clk); rst_n <= 1'b0; strap <= 1'b0; nr_strap <= 4'h4;
    tick(3);
    `CHK(pwr, 4'hF)
    @(posedge clk); rst_n <= 1'b1;
    tick(3);
    `CHK(pwr, 4'h0)
    reg_rd(8'h05, d); `CHK(d, 8'h00)
  endtask
  task t_disable;
    reg_wr(8'h00, 8'h01); vnd(4'h2);
    `CHK(pen, 4'hC)
    `CHK(pwr, 4'h3)
    reg_rd(8'h07, d); `CHK(d, 8'h0C)
    reg_wr(8'h00, 8'h00); vnd(4'h0);
    `CHK(pen, 4'hF)
  endtask
  task t_nonrem;
    @(posedge clk); ee_nr <= 4'h8; ee_v <= 1'b1;
    reg_wr(8'h01, 8'h01); tick(2);
    `CHK(pnr, 4'hD)
  endtask
  task t_cdp;
    reg_wr(8'h02, 8'h01); reg_wr(8'h04, 8'h01); tick(2);
    pd_run(8'd30, 1'b1); `CHK(done[0], 1'b1)
    reg_rd(8'h06, d); `CHK(d, 8'h01)
    pd_run(8'd5, 1'b1); `CHK(done[0], 1'b0)
    @(posedge clk); hold <= 8'd100; go <= 1'b1;
    @(posedge clk); go <= 1'b0;
    tick(86);
    #1 `CHK(dm[0], 1'b0)
    `CHK(pd_dp, 1'b1)
    tick(40);
    reg_wr(8'h04, 8'h00); tick(2);
    pd_run(8'd30, 1'b0); `CHK(pd_sdp, 1'b1)
    `CHK(done[0], 1'b0)
  endtask
  task t_dcp;
    reg_wr(8'h03, 8'h02); reg_wr(8'h04, 8'h03); tick(2);
    `CHK(shrt, 4'h2)
    `CHK(eblk, 4'h2)
    reg_wr(8'h04, 8'h01); tick(2);
    `CHK(shrt, 4'h0)
  endtask
  task t_ports;
    @(posedge clk); rst_n <= 1'b0;
    tick(3);
    smb_start; smb_byte(8'h4A, 1'b1); smb_byte(8'h05, 1'b1); smb_byte(8'h03, 1'b1);
    smb_byte(8'h02, 1'b1); smb_byte(8'h5A, 1'b1); smb_byte(8'h01, 1'b1);
    smb_byte(8'h77, 1'b0); smb_stop;
    @(posedge clk); rst_n <= 1'b1; ovc <= 4'h0;
    tick(4);
    `CHK(pen, 4'h6)
    `CHK(pwr, 4'h9)
    `CHK(pnr, 4'hE)
    `CHK(tune, 8'h5A)
    `CHK(vid, 16'h1234)
    `CHK(sd_out, 1'b0)
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    por_n = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    strap = 1'b1; nr_strap = 4'h0; ee_v = 1'b0; ee_nr = 4'h0; vnd_we = 1'b0;
    vnd_dis = 4'h0; ovc = 4'hC; go = 1'b0; hold = 8'h00;
    tick(6);
    @(posedge clk); por_n <= 1'b1;
    tick(3);
    t_config; t_release; t_polarity; t_disable; t_nonrem; t_cdp; t_dcp; t_ports;
    final_report;
  end

  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    final_report;
  end
endmodule
